// ===== hw/ibr_consts.svh
// Register map, field positions and reset values of the rate block
//
// Contract
// - The own slave address lives in bits 7..1 of the address register and is compared against incoming addresses.
// - That seven-bit field is the whole address in 7-bit mode and the low seven bits in 10-bit mode.
// - The multiplier field in bits 7..6 selects factor 1, 2 or 4, and code 11 is reserved.
// - The six-bit rate index in bits 5..0 selects the table entry and, with the multiplier, picks rate and holds.
// - The serial clock runs at bus clock over multiplier times the selected divider.
// - After each falling serial clock edge the data line changes only after multiplier times SDA hold bus periods.
// - For a start the clock falls multiplier times start hold bus periods after data fell with clock high.
// - For a stop the data line rises multiplier times stop hold bus periods after the clock rose.
// - Divider and the three holds come from a fixed table on the index, index 00 giving 20, 7, 6 and 11.
// - The table reaches index 1F with divider 240, SDA hold 33, start hold 118 and stop hold 121.
`ifndef IBR_CONSTS_SVH
`define IBR_CONSTS_SVH
`define IBR_OFS_OWN 4'h0
`define IBR_OFS_RATE 4'h1
`define IBR_OFS_STAT 4'h2
`define IBR_RST_OWN 8'h00
`define IBR_RST_RATE 8'h00
`define IBR_ADR_HI 7
`define IBR_ADR_LO 1
`define IBR_RATE_MULTIPLIER_HI 7
`define IBR_RATE_MULTIPLIER_LO 6
`define IBR_ICR_HI 5
`define IBR_RATE_MULTIPLIER_RSVD 2'h3
`endif

// ===== hw/ibr_pkg.sv
// Types shared by the rate block
package ibr_pkg;
  typedef logic [11:0] ibr_cnt_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_HELD = 3'b010,
    ST_LOW = 3'b011,
    ST_HIGH = 3'b100
  } ibr_state_e;

  typedef enum logic [1:0] {
    K_BIT = 2'b00,
    K_STOP = 2'b01,
    K_RSTART = 2'b10
  } ibr_kind_e;

  typedef struct packed {
    ibr_cnt_t div;
    ibr_cnt_t sda;
    ibr_cnt_t start;
    ibr_cnt_t stop;
  } ibr_rate_s;
endpackage : ibr_pkg

// ===== hw/ibr_rate_table.sv
// Fixed divider and hold table selected by the rate index
module ibr_rate_table
  import ibr_pkg::*;
(
  input wire logic [5:0] i_index,
  output ibr_rate_s o_rate
);
  ibr_rate_s r;

  always_comb begin
    case (i_index)
      6'h00: r = {12'd20, 12'd7, 12'd6, 12'd11};
      6'h01: r = {12'd22, 12'd7, 12'd7, 12'd12};
      6'h02: r = {12'd24, 12'd8, 12'd8, 12'd13};
      6'h03: r = {12'd26, 12'd8, 12'd9, 12'd14};
      6'h04: r = {12'd28, 12'd9, 12'd10, 12'd15};
      6'h05: r = {12'd30, 12'd9, 12'd11, 12'd16};
      6'h06: r = {12'd34, 12'd10, 12'd13, 12'd18};
      6'h07: r = {12'd40, 12'd10, 12'd16, 12'd21};
      6'h08: r = {12'd28, 12'd7, 12'd10, 12'd15};
      6'h09: r = {12'd32, 12'd7, 12'd12, 12'd17};
      6'h0a: r = {12'd36, 12'd9, 12'd14, 12'd19};
      6'h0b: r = {12'd40, 12'd9, 12'd16, 12'd21};
      6'h0c: r = {12'd44, 12'd11, 12'd18, 12'd23};
      6'h0d: r = {12'd48, 12'd11, 12'd20, 12'd25};
      6'h0e: r = {12'd56, 12'd13, 12'd24, 12'd29};
      6'h0f: r = {12'd68, 12'd13, 12'd30, 12'd35};
      6'h10: r = {12'd48, 12'd9, 12'd18, 12'd25};
      6'h11: r = {12'd56, 12'd9, 12'd22, 12'd29};
      6'h12: r = {12'd64, 12'd13, 12'd26, 12'd33};
      6'h13: r = {12'd72, 12'd13, 12'd30, 12'd37};
      6'h14: r = {12'd80, 12'd17, 12'd34, 12'd41};
      6'h15: r = {12'd88, 12'd17, 12'd38, 12'd45};
      6'h16: r = {12'd104, 12'd21, 12'd46, 12'd53};
      6'h17: r = {12'd128, 12'd21, 12'd58, 12'd65};
      6'h18: r = {12'd80, 12'd9, 12'd38, 12'd41};
      6'h19: r = {12'd96, 12'd9, 12'd46, 12'd49};
      6'h1a: r = {12'd112, 12'd17, 12'd54, 12'd57};
      6'h1b: r = {12'd128, 12'd17, 12'd62, 12'd65};
      6'h1c: r = {12'd144, 12'd25, 12'd70, 12'd73};
      6'h1d: r = {12'd160, 12'd25, 12'd78, 12'd81};
      6'h1e: r = {12'd192, 12'd33, 12'd94, 12'd97};
      6'h1f: r = {12'd240, 12'd33, 12'd118, 12'd121};
      6'h20: r = {12'd160, 12'd17, 12'd78, 12'd81};
      6'h21: r = {12'd192, 12'd17, 12'd94, 12'd97};
      6'h22: r = {12'd224, 12'd33, 12'd110, 12'd113};
      6'h23: r = {12'd256, 12'd33, 12'd126, 12'd129};
      6'h24: r = {12'd288, 12'd49, 12'd142, 12'd145};
      6'h25: r = {12'd320, 12'd49, 12'd158, 12'd161};
      6'h26: r = {12'd384, 12'd65, 12'd190, 12'd193};
      6'h27: r = {12'd480, 12'd65, 12'd238, 12'd241};
      6'h28: r = {12'd320, 12'd33, 12'd158, 12'd161};
      6'h29: r = {12'd384, 12'd33, 12'd190, 12'd193};
      6'h2a: r = {12'd448, 12'd65, 12'd222, 12'd225};
      6'h2b: r = {12'd512, 12'd65, 12'd254, 12'd257};
      6'h2c: r = {12'd576, 12'd97, 12'd286, 12'd289};
      6'h2d: r = {12'd640, 12'd97, 12'd318, 12'd321};
      6'h2e: r = {12'd768, 12'd129, 12'd382, 12'd385};
      6'h2f: r = {12'd960, 12'd129, 12'd478, 12'd481};
      6'h30: r = {12'd640, 12'd65, 12'd318, 12'd321};
      6'h31: r = {12'd768, 12'd65, 12'd382, 12'd385};
      6'h32: r = {12'd896, 12'd129, 12'd446, 12'd449};
      6'h33: r = {12'd1024, 12'd129, 12'd510, 12'd513};
      6'h34: r = {12'd1152, 12'd193, 12'd574, 12'd577};
      6'h35: r = {12'd1280, 12'd193, 12'd638, 12'd641};
      6'h36: r = {12'd1536, 12'd257, 12'd766, 12'd769};
      6'h37: r = {12'd1920, 12'd257, 12'd958, 12'd961};
      6'h38: r = {12'd1280, 12'd129, 12'd638, 12'd641};
      6'h39: r = {12'd1536, 12'd129, 12'd766, 12'd769};
      6'h3a: r = {12'd1792, 12'd257, 12'd894, 12'd897};
      6'h3b: r = {12'd2048, 12'd257, 12'd1022, 12'd1025};
      6'h3c: r = {12'd2304, 12'd385, 12'd1150, 12'd1153};
      6'h3d: r = {12'd2560, 12'd385, 12'd1278, 12'd1281};
      6'h3e: r = {12'd3072, 12'd513, 12'd1534, 12'd1537};
      6'h3f: r = {12'd3840, 12'd513, 12'd1918, 12'd1921};
      default: r = {12'd20, 12'd7, 12'd6, 12'd11};
    endcase
  end

  assign o_rate = r;
endmodule : ibr_rate_table

// ===== hw/ibr_top.sv
// Own address, bit-rate generator and bit-level line sequencer
//
// Design decisions made here: the strobed register port and the placing of the registers.
`include "ibr_consts.svh"

module ibr_top
  import ibr_pkg::*;
#(
  parameter int ADDR_W = 4
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_cmd_start,
  input wire logic i_cmd_bit,
  input wire logic i_cmd_stop,
  input wire logic i_bit_val,
  output logic o_ready,
  output logic o_done,
  output logic o_rx_bit,
  input wire logic i_scl,
  output logic o_scl_o,
  output logic o_scl_oe,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  input wire logic i_cmp_valid,
  input wire logic i_cmp_ten,
  input wire logic [9:0] i_cmp_addr,
  output logic o_addr_match
);
  localparam int LO = `IBR_ADR_LO;
  localparam int HI = `IBR_ADR_HI;

  logic [HI-LO:0] own_q, own_d;
  logic [7:0] rate_q, rate_d;
  logic [7:0] rdata_q, rdata_d;
  logic match_q, match_d;
  logic seen_q, seen_d;

  ibr_state_e st_q, st_d;
  ibr_kind_e kind_q, kind_d;
  logic bitv_q, bitv_d;
  logic scl_q, scl_d;
  logic sda_q, sda_d;
  logic done_q, done_d;
  logic rx_q, rx_d;
  logic ready_q, ready_d;
  logic [2:0] pre_q, pre_d;
  ibr_cnt_t cnt_q, cnt_d;
  logic [15:0] cyc_q, cyc_d;

  ibr_rate_s tbl;
  logic [1:0] shift;
  logic [2:0] mul;
  ibr_cnt_t lo_half;
  ibr_cnt_t hi_half;
  logic run;
  logic tick;
  logic enter;

  ibr_rate_table u_table (
    .i_index(rate_q[`IBR_ICR_HI:0]),
    .o_rate(tbl)
  );

  // Reserved multiplier code falls back to factor 1
  assign shift = (rate_q[`IBR_RATE_MULTIPLIER_HI:`IBR_RATE_MULTIPLIER_LO] == `IBR_RATE_MULTIPLIER_RSVD) ?
                 2'h0 : rate_q[`IBR_RATE_MULTIPLIER_HI:`IBR_RATE_MULTIPLIER_LO];
  assign mul = 3'h1 << shift;
  assign lo_half = tbl.div >> 1;
  assign hi_half = tbl.div - lo_half;

  // High phase waits while another device stretches the clock
  assign run = (st_q == ST_START) || (st_q == ST_LOW) ||
               ((st_q == ST_HIGH) && i_scl);
  assign tick = run && (pre_q == mul - 3'h1);

  // Register file and address compare
  always_comb begin
    own_d = own_q;
    rate_d = rate_q;
    rdata_d = 8'h00;
    seen_d = seen_q;
    if (i_wr && (i_addr == `IBR_OFS_OWN)) begin
      own_d = i_wdata[HI:LO];
    end
    if (i_wr && (i_addr == `IBR_OFS_RATE)) begin
      rate_d = i_wdata;
    end
    if (i_wr && (i_addr == `IBR_OFS_STAT) && i_wdata[6]) begin
      seen_d = 1'b0;
    end
    if (i_rd) begin
      case (i_addr)
        `IBR_OFS_OWN: rdata_d = {own_q, 1'b0};
        `IBR_OFS_RATE: rdata_d = rate_q;
        `IBR_OFS_STAT: rdata_d = {!ready_q, seen_q, rx_q, 2'h0, st_q};
        default: rdata_d = 8'h00;
      endcase
    end
    // Seven-bit mode wants the upper three bits clear
    match_d = i_cmp_valid && (i_cmp_addr[6:0] == own_q) &&
              (i_cmp_ten || (i_cmp_addr[9:7] == 3'h0));
    if (match_d) begin
      seen_d = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      own_q <= (HI-LO+1)'(`IBR_RST_OWN >> LO);
      rate_q <= `IBR_RST_RATE;
      rdata_q <= 8'h00;
      match_q <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      own_q <= own_d;
      rate_q <= rate_d;
      rdata_q <= rdata_d;
      match_q <= match_d;
      seen_q <= seen_d;
    end
  end

  // Line sequencer
  always_comb begin
    st_d = st_q;
    kind_d = kind_q;
    bitv_d = bitv_q;
    scl_d = scl_q;
    sda_d = sda_q;
    done_d = 1'b0;
    rx_d = rx_q;
    pre_d = pre_q;
    cnt_d = cnt_q;
    cyc_d = cyc_q;
    enter = 1'b0;
    if (run) begin
      cyc_d = cyc_q + 16'h0001;
      if (tick) begin
        pre_d = 3'h0;
        cnt_d = cnt_q + 12'h001;
      end else begin
        pre_d = pre_q + 3'h1;
      end
    end
    case (st_q)
      ST_IDLE: begin
        if (i_cmd_start && i_scl && i_sda) begin
          sda_d = 1'b1;
          st_d = ST_START;
          enter = 1'b1;
        end
      end
      ST_START: begin
        if (tick && (cnt_q == tbl.start - 12'h001)) begin
          scl_d = 1'b1;
          st_d = ST_HELD;
          done_d = 1'b1;
          enter = 1'b1;
        end
      end
      ST_HELD: begin
        if (i_cmd_start) begin
          kind_d = K_RSTART;
          st_d = ST_LOW;
          enter = 1'b1;
        end else if (i_cmd_stop) begin
          kind_d = K_STOP;
          st_d = ST_LOW;
          enter = 1'b1;
        end else if (i_cmd_bit) begin
          kind_d = K_BIT;
          bitv_d = i_bit_val;
          st_d = ST_LOW;
          enter = 1'b1;
        end
      end
      ST_LOW: begin
        if (tick && (cnt_q == tbl.sda - 12'h001)) begin
          case (kind_q)
            K_BIT: sda_d = !bitv_q;
            K_STOP: sda_d = 1'b1;
            default: sda_d = 1'b0;
          endcase
        end
        if (tick && (cnt_q == lo_half - 12'h001)) begin
          scl_d = 1'b0;
          st_d = ST_HIGH;
          enter = 1'b1;
        end
      end
      ST_HIGH: begin
        if (kind_q == K_STOP) begin
          if (tick && (cnt_q == tbl.stop - 12'h001)) begin
            sda_d = 1'b0;
            st_d = ST_IDLE;
            done_d = 1'b1;
            enter = 1'b1;
          end
        end else if (tick && (cnt_q == hi_half - 12'h001)) begin
          rx_d = i_sda;
          enter = 1'b1;
          if (kind_q == K_RSTART) begin
            sda_d = 1'b1;
            st_d = ST_START;
          end else begin
            scl_d = 1'b1;
            st_d = ST_HELD;
            done_d = 1'b1;
          end
        end
      end
      default: begin
        st_d = ST_IDLE;
        scl_d = 1'b0;
        sda_d = 1'b0;
      end
    endcase
    if (enter) begin
      pre_d = 3'h0;
      cnt_d = 12'h000;
      cyc_d = 16'h0000;
    end
    ready_d = (st_d == ST_IDLE) || (st_d == ST_HELD);
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= ST_IDLE;
      kind_q <= K_BIT;
      bitv_q <= 1'b0;
      scl_q <= 1'b0;
      sda_q <= 1'b0;
      done_q <= 1'b0;
      rx_q <= 1'b0;
      ready_q <= 1'b1;
      pre_q <= 3'h0;
      cnt_q <= 12'h000;
      cyc_q <= 16'h0000;
    end else begin
      st_q <= st_d;
      kind_q <= kind_d;
      bitv_q <= bitv_d;
      scl_q <= scl_d;
      sda_q <= sda_d;
      done_q <= done_d;
      rx_q <= rx_d;
      ready_q <= ready_d;
      pre_q <= pre_d;
      cnt_q <= cnt_d;
      cyc_q <= cyc_d;
    end
  end

  // Open-drain pins only ever pull low
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_scl_o <= 1'b0;
      o_sda_o <= 1'b0;
    end else begin
      o_scl_o <= 1'b0;
      o_sda_o <= 1'b0;
    end
  end

  assign o_rdata = rdata_q;
  assign o_addr_match = match_q;
  assign o_scl_oe = scl_q;
  assign o_sda_oe = sda_q;
  assign o_done = done_q;
  assign o_ready = ready_q;
  assign o_rx_bit = rx_q;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_start_done;
    o_scl_oe && o_sda_oe && o_done && o_ready;
  endsequence
  sequence s_stop_done;
    !o_sda_oe && !o_scl_oe && o_done ##1 !o_done && o_ready;
  endsequence

  a_match_seven: assert property (
    i_cmp_valid && !i_cmp_ten && (i_cmp_addr[6:0] != own_q)
    |=> !o_addr_match)
    else $error("seven-bit mismatch reported as match");

  a_match_ten: assert property (
    i_cmp_valid && i_cmp_ten && (i_cmp_addr[6:0] == own_q)
    |=> o_addr_match)
    else $error("ten-bit low bits match missed");

  a_rate_multiplier_four: assert property (
    (st_q == ST_LOW) && (rate_q[7:6] == 2'h2) && (pre_q == 3'h0) &&
    $stable(rate_q) |-> !tick ##1 !tick ##1 !tick ##1 tick)
    else $error("factor four tick spacing wrong");

  a_rate_multiplier_rsvd: assert property (
    run && (rate_q[7:6] == 2'h3) |-> tick)
    else $error("reserved multiplier not treated as one");

  a_scl_low_len: assert property (
    (st_q == ST_LOW) && $stable(rate_q) &&
    (cyc_q == mul * lo_half - 1)
    |=> !o_scl_oe && (st_q == ST_HIGH))
    else $error("clock low phase length wrong");

  a_sda_hold: assert property (
    (st_q == ST_LOW) && (kind_q == K_BIT) && $stable(rate_q) &&
    (cyc_q == mul * tbl.sda - 1) |-> $stable(o_sda_oe) ##1 (o_sda_oe ^ bitv_q))
    else $error("data changed at wrong hold time");

  a_start_hold: assert property (
    (st_q == ST_START) && $stable(rate_q) &&
    (cyc_q == mul * tbl.start - 1) |-> !o_scl_oe ##1 s_start_done)
    else $error("start hold time wrong");

  a_stop_hold: assert property (
    (st_q == ST_HIGH) && (kind_q == K_STOP) && run && $stable(rate_q) &&
    (cyc_q == mul * tbl.stop - 1) |-> o_sda_oe ##1 s_stop_done)
    else $error("stop hold time wrong");

  a_table_first: assert property (
    (rate_q[5:0] == 6'h00) |->
    (tbl.div == 12'd20) && (tbl.sda == 12'd7) &&
    (tbl.start == 12'd6) && (tbl.stop == 12'd11))
    else $error("index 00 table entry wrong");
  a_table_last: assert property (
    (rate_q[5:0] == 6'h1f) |->
    (tbl.div == 12'd240) && (tbl.sda == 12'd33) &&
    (tbl.start == 12'd118) && (tbl.stop == 12'd121))
    else $error("index 1f table entry wrong");
endmodule : ibr_top

// ===== testbench/ibr_bus_partner.sv
// Other devices on the two-wire bus: pull-ups, clock stretch, acknowledge
module ibr_bus_partner (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_scl_oe,
  input wire logic i_sda_oe,
  input wire logic [7:0] i_stretch,
  input wire logic i_ack,
  output logic o_scl,
  output logic o_sda
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev_q;
  logic [7:0] cnt_q;
  logic rel;
  logic hold;
  assign rel = prev_q && !i_scl_oe && (i_stretch != 8'h00);
  // Stretch starts in the very cycle the block lets SCL go
  assign hold = (cnt_q != 8'h00) || rel;
  // Released lines float high through the pull-ups
  assign o_scl = !(i_scl_oe || hold);
  assign o_sda = !(i_sda_oe || i_ack);
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev_q <= 1'b0;
      cnt_q <= 8'h00;
    end else begin
      prev_q <= i_scl_oe;
      if (rel) begin
        cnt_q <= i_stretch - 8'h01;
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
endmodule : ibr_bus_partner

// ===== testbench/tb_ibr_top.sv
// Self-checking bench for the own-address and bit-rate block
`include "ibr_consts.svh"

module tb_ibr_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic c_start = 1'b0;
  logic c_bit = 1'b0;
  logic c_stop = 1'b0;
  logic bit_val = 1'b0;
  logic ready, done, rx_bit, scl, scl_oe, sda, sda_oe, match;
  logic cmp_valid = 1'b0;
  logic cmp_ten = 1'b0;
  logic [9:0] cmp_addr = 10'h000;
  logic [7:0] stretch = 8'h00;
  logic ack = 1'b0;
  int err_total = 0;
  int num_checks = 0;
  int cycles = 0;

  always #10 clk = ~clk;

  ibr_top dut_u (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_cmd_start(c_start),
    .i_cmd_bit(c_bit), .i_cmd_stop(c_stop), .i_bit_val(bit_val),
    .o_ready(ready), .o_done(done), .o_rx_bit(rx_bit), .i_scl(scl),
    .o_scl_o(), .o_scl_oe(scl_oe), .i_sda(sda), .o_sda_o(),
    .o_sda_oe(sda_oe), .i_cmp_valid(cmp_valid), .i_cmp_ten(cmp_ten),
    .i_cmp_addr(cmp_addr), .o_addr_match(match)
  );

  ibr_bus_partner bus_u (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_scl_oe(scl_oe),
    .i_sda_oe(sda_oe), .i_stretch(stretch), .i_ack(ack),
    .o_scl(scl), .o_sda(sda)
  );

  task automatic test_done();
    $display("Checks %0d, errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      test_done();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk({8'h00, rdata}, {8'h00, exp});
  endtask : reg_rd

  task automatic cmp_try(input logic ten, input logic [9:0] a,
                         input logic exp);
    @(posedge clk);
    cmp_valid <= 1'b1;
    cmp_ten <= ten;
    cmp_addr <= a;
    @(posedge clk);
    cmp_valid <= 1'b0;
    #1;
    chk({15'h0000, match}, {15'h0000, exp});
  endtask : cmp_try

  // Cycles counted from the command cycle: last SDA change, SCL release, done
  task automatic line_cmd(input int kind, input logic v, output int ts,
                          output int tc, output int td);
    logic ps;
    logic pc;
    int n;
    ps = sda_oe;
    pc = scl_oe;
    ts = -1;
    tc = -1;
    td = -1;
    n = 0;
    @(posedge clk);
    bit_val <= v;
    c_start <= (kind == 0);
    c_bit <= (kind == 1);
    c_stop <= (kind == 2);
    @(posedge clk);
    c_start <= 1'b0;
    c_bit <= 1'b0;
    c_stop <= 1'b0;
    while (td < 0 && n < 3000) begin
      n++;
      #1;
      if (n == 1) chk({15'h0000, ready}, 16'h0000);
      if (sda_oe !== ps) ts = n;
      if (pc === 1'b1 && scl_oe === 1'b0) tc = n;
      ps = sda_oe;
      pc = scl_oe;
      if (done === 1'b1) td = n;
      else @(posedge clk);
    end
    chk({15'h0000, ready}, 16'h0001);
  endtask : line_cmd

  task automatic reg_run();
    reg_rd(`IBR_OFS_OWN, 8'h00);
    reg_rd(`IBR_OFS_RATE, 8'h00);
    reg_rd(4'hf, 8'h00);
    reg_wr(`IBR_OFS_RATE, 8'hc7);
    reg_rd(`IBR_OFS_RATE, 8'hc7);
  endtask : reg_run

  task automatic addr_run();
    reg_wr(`IBR_OFS_OWN, 8'ha5);
    reg_rd(`IBR_OFS_OWN, 8'ha4);
    cmp_try(1'b0, 10'h052, 1'b1);
    cmp_try(1'b0, 10'h053, 1'b0);
    cmp_try(1'b0, 10'h252, 1'b0);
    cmp_try(1'b1, 10'h252, 1'b1);
    cmp_try(1'b1, 10'h353, 1'b0);
  endtask : addr_run

  // Sticky match flag: readback, clear, and a match beating a clear
  task automatic stat_run();
    reg_rd(`IBR_OFS_STAT, 8'h40);
    reg_wr(`IBR_OFS_STAT, 8'h40);
    reg_rd(`IBR_OFS_STAT, 8'h00);
    @(posedge clk);
    cmp_valid <= 1'b1;
    cmp_ten <= 1'b0;
    cmp_addr <= 10'h052;
    addr <= `IBR_OFS_STAT;
    wdata <= 8'h40;
    wr <= 1'b1;
    @(posedge clk);
    cmp_valid <= 1'b0;
    wr <= 1'b0;
    reg_rd(`IBR_OFS_STAT, 8'h40);
  endtask : stat_run

  task automatic rate_run(input logic [7:0] rate, input int m, input int dv,
                          input int sh, input int st, input int sp,
                          input logic [7:0] s);
    int ts, tc, td, lo;
    lo = m * (dv / 2);
    reg_wr(`IBR_OFS_RATE, rate);
    line_cmd(0, 1'b0, ts, tc, td);
    chk(16'(ts), 16'(1));
    chk(16'(td), 16'(1 + m * st));
    chk({15'h0000, scl_oe}, 16'h0001);
    stretch = s;
    line_cmd(1, 1'b1, ts, tc, td);
    chk(16'(ts), 16'(1 + m * sh));
    chk(16'(tc), 16'(1 + lo));
    chk(16'(td), 16'(1 + m * dv + s));
    chk({15'h0000, rx_bit}, 16'h0001);
    stretch = 8'h00;
    line_cmd(1, 1'b0, ts, tc, td);
    chk(16'(ts), 16'(1 + m * sh));
    chk(16'(td), 16'(1 + m * dv));
    ack = 1'b1;
    line_cmd(1, 1'b1, ts, tc, td);
    chk(16'(ts), 16'(1 + m * sh));
    chk({15'h0000, rx_bit}, 16'h0000);
    ack = 1'b0;
    // Repeated start: SDA falls after a full clock, then start hold
    line_cmd(0, 1'b0, ts, tc, td);
    chk(16'(tc), 16'(1 + lo));
    chk(16'(ts), 16'(1 + m * dv));
    chk(16'(td), 16'(1 + m * dv + m * st));
    line_cmd(2, 1'b0, ts, tc, td);
    chk(16'(tc), 16'(1 + lo));
    chk(16'(ts), 16'(1 + lo + m * sp));
    chk(16'(td), 16'(1 + lo + m * sp));
    chk({15'h0000, sda_oe}, 16'h0000);
  endtask : rate_run

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    reg_run();
    addr_run();
    stat_run();
    rate_run(8'h00, 1, 20, 7, 6, 11, 8'h00);
    rate_run(8'h5f, 2, 240, 33, 118, 121, 8'h00);
    rate_run(8'h8b, 4, 40, 9, 16, 21, 8'h03);
    rate_run(8'hc7, 1, 40, 10, 16, 21, 8'h02);
    test_done();
  end
endmodule : tb_ibr_top
